// file: cfpl_defines.vh
// cfpl_defines.vh: constants for the code flash program and lock port.
// assumes a 250 MHz core clock; included by bare name from every design file.
`ifndef CFPL_DEFINES_VH
`define CFPL_DEFINES_VH

// clock period in ps and derived cycle counts
`define CFPL_CLK_PS         32'd4000
`define CFPL_WRITE_US       32'd50
`define CFPL_WRITE_CYC      ((`CFPL_WRITE_US * 32'd1000000) / `CFPL_CLK_PS)
`define CFPL_ERASE_MS       32'd500
`define CFPL_ERASE_CYC      ((`CFPL_ERASE_MS * 32'd1000) * (32'd1000000 / `CFPL_CLK_PS))
`define CFPL_BUSY_NS        32'd1000
`define CFPL_BUSY_CYC       ((`CFPL_BUSY_NS * 32'd1000) / `CFPL_CLK_PS)

// array geometry and data values
`define CFPL_AW             13
`define CFPL_ERASED         8'hff
`define CFPL_ERASING_RD     8'h00

// parallel mode control codes {p26,p27,p33,p36,p37}
`define CFPL_PM_WR_CODE     5'h0f
`define CFPL_PM_RD_CODE     5'h03
`define CFPL_PM_WR_LB1      5'h1f
`define CFPL_PM_WR_LB2      5'h1c
`define CFPL_PM_WR_LB3      5'h16
`define CFPL_PM_RD_LOCK     5'h1a
`define CFPL_PM_ERASE       5'h14
`define CFPL_PM_RD_SIG      5'h00

// lock read bit positions on the data lines
`define CFPL_LB1_POS        2
`define CFPL_LB2_POS        3
`define CFPL_LB3_POS        4

// signature locations (address bits 9:8)
`define CFPL_SIG0_HI        2'h0
`define CFPL_SIG1_HI        2'h1
`define CFPL_SIG2_HI        2'h2

// serial opcodes (first byte of the four-byte frame; CFPL_SO_ERASE_B2 is the second byte)
`define CFPL_SO_ENABLE      8'hac
`define CFPL_SO_ERASE_B2    8'h80
`define CFPL_SO_READ        3'h1
`define CFPL_SO_WRITE       3'h2
`define CFPL_FRAME_BITS     6'd32

`endif

// file: cfpl_serial_rx.v
// cfpl_serial_rx.v: four-byte serial frame shifter for the programming link.
// assumes sck, mosi and the frame gate are already two-flop synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "cfpl_defines.vh"

module cfpl_serial_rx (
   input  wire        clock_i,     // core clock
   input  wire        rst_b_i,     // sync reset, active low
   input  wire        active_i,    // serial mode allowed (reset pin high)
   input  wire        sck_s_i,     // synchronised shift clock
   input  wire        mosi_s_i,    // synchronised serial data in
   input  wire [7:0]  tx_byte_i,   // byte to return in the fourth slot
   output reg         miso_o,      // serial data out
   output reg         frame_o,     // pulse: full 32 bit frame received
   output reg  [31:0] word_o       // received frame, first byte on top
);

   reg        sck_q;               // previous sampled shift clock
   reg [5:0]  cnt_q;               // bits received in this frame
   reg [31:0] sh_q;                // shift register
   reg [7:0]  tx_q;                // output shifter

   // edge detect
   // edges come from the core clock sampling sck, never sck as a clock
   always @(posedge clock_i) begin
      if (!rst_b_i || !active_i) begin
         sck_q   <= 1'b0;
         cnt_q   <= 6'd0;
         sh_q    <= 32'h0000_0000;
         tx_q    <= 8'h00;
         miso_o  <= 1'b0;
         frame_o <= 1'b0;
         word_o  <= 32'h0000_0000;
      end else begin
         sck_q   <= sck_s_i;
         frame_o <= 1'b0;
         // rising edge: sample mosi
         if (sck_s_i && !sck_q) begin
            sh_q <= {sh_q[30:0], mosi_s_i};
            if (cnt_q == `CFPL_FRAME_BITS - 6'd1) begin
               cnt_q   <= 6'd0;
               frame_o <= 1'b1;
               word_o  <= {sh_q[30:0], mosi_s_i};
            end else begin
               cnt_q <= cnt_q + 6'd1;
            end
            // load read byte just before the fourth slot
            if (cnt_q == 6'd23)
               tx_q <= tx_byte_i;
         end
         // falling edge: present next bit
         if (!sck_s_i && sck_q) begin
            miso_o <= (cnt_q >= 6'd24) ? tx_q[7] : 1'b0;
            if (cnt_q >= 6'd24)
               tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

endmodule // cfpl_serial_rx
`default_nettype wire

// file: cfpl_port.v
// cfpl_port.v: code flash programming port with three-level lock.
// assumes pins are asynchronous and pass two flops; array is flip-flops.
`timescale 1ns/10ps
`default_nettype none
`include "cfpl_defines.vh"

module cfpl_port #(
   parameter                  DEPTH     = 8192,            // array bytes
   parameter [31:0]           WRITE_CYC = `CFPL_WRITE_CYC, // byte write time
   parameter [31:0]           ERASE_CYC = `CFPL_ERASE_CYC, // erase time
   parameter [7:0]            SIG0      = 8'h11,           // arbitrary value
   parameter [7:0]            SIG1      = 8'h22,           // arbitrary value
   parameter [7:0]            SIG2      = 8'h33            // arbitrary value
) (
   input  wire                clock_i,        // 250 MHz core clock
   input  wire                rst_b_i,        // sync reset, active low
   input  wire                reset_pin_i,    // device reset pin, high = programming
   input  wire                hv_enable_i,    // ext_access_hv_enable_pin at high voltage
   input  wire                ext_access_i,   // ext_access_hv_enable_pin logic level
   input  wire                program_strobe_i, // program_strobe_pin, active low pulse
   input  wire [4:0]          mode_i,         // {p26,p27,p33,p36,p37}
   input  wire [12:0]         addr_i,         // parallel address
   input  wire [7:0]          data_i,         // parallel data in
   input  wire                sck_i,          // serial shift clock
   input  wire                mosi_i,         // serial data in
   input  wire                cpu_ext_fetch_i, // cpu executing from external memory
   output reg  [7:0]          data_o,         // parallel data out
   output reg                 data_oe_o,      // data lines driven
   output reg                 ready_busy_o,   // ready_busy_out, low = busy
   output reg                 miso_o,         // serial data out
   output reg                 miso_oe_o,      // serial output driven
   output reg                 table_read_block_o, // table_read_instruction blocked
   output reg                 ext_exec_block_o,   // external execution refused
   output reg                 ext_access_latch_o, // latched access level when the first lock is set, live access level otherwise
   output reg  [2:0]          lock_bits_o     // {third,second,first}
);

   // states, one-hot
   localparam [3:0] ST_IDLE  = 4'b0001;   // waiting
   localparam [3:0] ST_WRITE = 4'b0010;   // timed byte write
   localparam [3:0] ST_ERASE = 4'b0100;   // timed chip erase
   localparam [3:0] ST_LOCK  = 4'b1000;   // timed lock write

   // two-flop synchronisers for every pin
   reg [8:0]  s1_q;                       // first stage, read only by s2
   reg [8:0]  s2_q;                       // second stage
   reg [12:0] addr_s1_q, addr_s2_q;       // address sync
   reg [7:0]  data_s1_q, data_s2_q;       // data sync
   reg [4:0]  mode_s1_q, mode_s2_q;       // mode sync

   reg [7:0]  mem_q [0:DEPTH-1];          // code array
   reg [3:0]  st_q;                       // state
   reg [31:0] tmr_q;                      // operation timer
   reg [12:0] last_a_q;                   // last byte address written
   reg [7:0]  last_d_q;                   // last byte value written
   reg        lock1_q, lock2_q, lock3_q;  // lock bits
   reg        ser_en_q;                   // programming enable seen
   reg        strb_q;                     // previous strobe level
   reg        rst_pin_q;                  // previous reset pin level
   reg        ea_lat_q;                   // latched access level
   reg [2:0]  lock_sel_q;                 // lock bit being written

   wire       rst_pin_s  = s2_q[0];
   wire       hv_s       = s2_q[1];
   wire       ea_s       = s2_q[2];
   wire       strb_s     = s2_q[3];
   wire       sck_s      = s2_q[4];
   wire       mosi_s     = s2_q[5];
   wire       cpu_ext_s  = s2_q[6];
   wire       busy       = !st_q[0];
   wire       strobe_rise = strb_s && !strb_q;

   // programming refused
   // any lock-one state forbids writes of code; lock writes still pass (lock can only rise)
   wire       prog_ok    = !lock1_q;
   wire       verify_ok  = !lock1_q && !lock2_q;

   wire        rx_frame;                  // frame pulse
   wire [31:0] rx_word;                   // frame content
   wire        rx_miso;                   // serial bit out
   reg  [7:0]  ser_rd;                    // serial read answer

   // array read with polling and erase behaviour
   function [7:0] rd_byte;
      input [12:0] a;
      input        ser;
      begin
         if (st_q[2])
            rd_byte = `CFPL_ERASING_RD;
         else if (st_q[1] && a == last_a_q)
            rd_byte = {~last_d_q[7], ser ? 7'h00 : last_d_q[6:0]} | (ser ? {1'b0, last_d_q[6:0]} : 8'h00);
         else
            rd_byte = mem_q[a];
      end
   endfunction

   // synchronise all pins
   always @(posedge clock_i) begin
      s1_q      <= {2'b00, cpu_ext_fetch_i, mosi_i, sck_i, program_strobe_i, ext_access_i, hv_enable_i, reset_pin_i};
      s2_q      <= s1_q;
      addr_s1_q <= addr_i;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= data_i;
      data_s2_q <= data_s1_q;
      mode_s1_q <= mode_i;
      mode_s2_q <= mode_s1_q;
   end

   // address held in the partial frame (bytes two and three)
   reg [31:0] rx_shadow;                  // mirror of incoming bits
   reg        sck_m_q;                    // edge helper for the mirror
   function [12:0] addr_sh;
      input [31:0] w;
      begin
         addr_sh = {w[12:8], w[7:0]};
      end
   endfunction
   always @(posedge clock_i) begin
      if (!rst_b_i || !rst_pin_s) begin
         rx_shadow <= 32'h0000_0000;
         sck_m_q   <= 1'b0;
      end else begin
         sck_m_q <= sck_s;
         if (sck_s && !sck_m_q)
            rx_shadow <= {rx_shadow[30:0], mosi_s};
      end
   end

   // serial read answer; the last address bit comes on the edge that loads it
   always @* begin
      ser_rd = verify_ok ? rd_byte(addr_sh({rx_shadow[30:0], mosi_s}), 1'b1) : `CFPL_ERASING_RD;
      if (st_q[2])
         ser_rd = `CFPL_ERASING_RD;
   end

   // serial only with reset pin high
   cfpl_serial_rx u_rx (
      .clock_i   (clock_i),
      .rst_b_i   (rst_b_i),
      .active_i  (rst_pin_s),
      .sck_s_i   (sck_s),
      .mosi_s_i  (mosi_s),
      .tx_byte_i (ser_rd),
      .miso_o    (rx_miso),
      .frame_o   (rx_frame),
      .word_o    (rx_word)
   );

   // main control: parallel and serial commands, timers, locks
   integer i;
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         st_q       <= ST_IDLE;
         tmr_q      <= 32'h0000_0000;
         last_a_q   <= 13'h0000;
         last_d_q   <= 8'h00;
         lock1_q    <= 1'b0;
         lock2_q    <= 1'b0;
         lock3_q    <= 1'b0;
         ser_en_q   <= 1'b0;
         strb_q     <= 1'b1;
         rst_pin_q  <= 1'b0;
         ea_lat_q   <= 1'b0;
         lock_sel_q <= 3'b000;
      end else begin
         strb_q    <= strb_s;
         rst_pin_q <= rst_pin_s;
         if (lock1_q && rst_pin_s)
            ea_lat_q <= ea_s;
         if (!rst_pin_s || (rst_pin_s && !rst_pin_q))
            ser_en_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               // parallel strobe completes on rising edge (busy follows)
               if (strobe_rise && hv_s && rst_pin_s) begin
                  if (mode_s2_q == `CFPL_PM_WR_CODE && prog_ok) begin
                     st_q     <= ST_WRITE;
                     tmr_q    <= WRITE_CYC;
                     last_a_q <= addr_s2_q;
                     last_d_q <= data_s2_q;
                  end else if (mode_s2_q == `CFPL_PM_ERASE) begin
                     st_q  <= ST_ERASE;
                     tmr_q <= WRITE_CYC;
                  end else if (mode_s2_q == `CFPL_PM_WR_LB1 || mode_s2_q == `CFPL_PM_WR_LB2
                               || mode_s2_q == `CFPL_PM_WR_LB3) begin
                     st_q       <= ST_LOCK;
                     tmr_q      <= WRITE_CYC;
                     lock_sel_q <= {mode_s2_q == `CFPL_PM_WR_LB3, mode_s2_q == `CFPL_PM_WR_LB2,
                                    mode_s2_q == `CFPL_PM_WR_LB1};
                  end
               end else if (rx_frame) begin
                  if (rx_word[31:24] == `CFPL_SO_ENABLE && rx_word[23:16] != `CFPL_SO_ERASE_B2)
                     ser_en_q <= 1'b1;
                  else if (ser_en_q) begin
                     if (rx_word[31:24] == `CFPL_SO_ENABLE) begin
                        st_q  <= ST_ERASE;
                        tmr_q <= ERASE_CYC;
                     end else if (rx_word[26:24] == `CFPL_SO_WRITE && prog_ok) begin
                        st_q     <= ST_WRITE;
                        tmr_q    <= WRITE_CYC;
                        last_a_q <= rx_word[`CFPL_AW+7:8];
                        last_d_q <= rx_word[7:0];
                     end
                  end
               end
            end
            ST_WRITE, ST_ERASE, ST_LOCK: begin
               if (tmr_q <= 32'd1) begin
                  st_q <= ST_IDLE;
                  if (st_q[1])
                     mem_q[last_a_q] <= last_d_q;
                  // erase sets all ones, clears locks
                  if (st_q[2]) begin
                     for (i = 0; i < DEPTH; i = i + 1)
                        mem_q[i] <= `CFPL_ERASED;
                     lock1_q <= 1'b0;
                     lock2_q <= 1'b0;
                     lock3_q <= 1'b0;
                  end
                  if (st_q[3]) begin
                     lock1_q <= lock1_q | lock_sel_q[0];
                     lock2_q <= lock2_q | lock_sel_q[1];
                     lock3_q <= lock3_q | lock_sel_q[2];
                  end
               end else begin
                  tmr_q <= tmr_q - 32'd1;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // registered outputs
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         data_o             <= 8'h00;
         data_oe_o          <= 1'b0;
         ready_busy_o       <= 1'b1;
         miso_o             <= 1'b0;
         miso_oe_o          <= 1'b0;
         table_read_block_o <= 1'b0;
         ext_exec_block_o   <= 1'b0;
         ext_access_latch_o <= 1'b0;
         lock_bits_o        <= 3'b000;
      end else begin
         ready_busy_o <= !busy;
         miso_o       <= rx_miso;
         miso_oe_o    <= rst_pin_s && ser_en_q;
         table_read_block_o <= lock1_q;
         ext_exec_block_o   <= lock3_q && lock2_q && lock1_q && cpu_ext_s;
         ext_access_latch_o <= lock1_q ? ea_lat_q : ea_s;
         lock_bits_o        <= {lock3_q, lock2_q, lock1_q};
         data_oe_o          <= 1'b0;
         data_o             <= 8'h00;
         if (rst_pin_s && !hv_s) begin
            case (mode_s2_q)
               `CFPL_PM_RD_CODE: begin
                  data_oe_o <= verify_ok;
                  data_o    <= verify_ok ? rd_byte(addr_s2_q, 1'b0) : 8'h00;
               end
               `CFPL_PM_RD_LOCK: begin
                  data_oe_o <= 1'b1;
                  data_o    <= {3'b000, lock3_q, lock2_q, lock1_q, 2'b00};
               end
               `CFPL_PM_RD_SIG: begin
                  data_oe_o <= 1'b1;
                  data_o    <= (addr_s2_q[9:8] == `CFPL_SIG0_HI) ? SIG0 :
                               (addr_s2_q[9:8] == `CFPL_SIG1_HI) ? SIG1 :
                               (addr_s2_q[9:8] == `CFPL_SIG2_HI) ? SIG2 : 8'h00;
               end
               default: data_oe_o <= 1'b0;
            endcase
         end
      end
   end

endmodule // cfpl_port
`default_nettype wire

// file: cfpl_port_checker.sv
// cfpl_port_checker.sv: concurrent checks on the flash programming port.
// assumes it is bound to cfpl_port and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "cfpl_defines.vh"

module cfpl_port_checker #(
   parameter [31:0] ERASE_CYC = 32'h0fa0, // longest self-timed busy span
   parameter [7:0]  SIG0      = 8'h11     // byte at signature location zero
) (
   input wire logic        clock_i,
   input wire logic        rst_b_i,
   input wire logic        reset_pin_i,
   input wire logic        hv_enable_i,
   input wire logic        program_strobe_i,
   input wire logic [4:0]  mode_i,
   input wire logic [12:0] addr_i,
   input wire logic        cpu_ext_fetch_i,
   input wire logic [7:0]  data_o,
   input wire logic        data_oe_o,
   input wire logic        ready_busy_o,
   input wire logic        miso_oe_o,
   input wire logic        table_read_block_o,
   input wire logic        ext_exec_block_o,
   input wire logic [2:0]  lock_bits_o
);
   logic [31:0] busy_cnt_q; // cycles spent busy, a counter beats a repetition

   // busy span counter, cleared whenever ready shows
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || ready_busy_o) begin
         busy_cnt_q <= 32'h0;
      end else begin
         busy_cnt_q <= busy_cnt_q + 32'h1;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   AST_NO_LOCK_NO_BLOCK: assert property (lock_bits_o == 3'h0 && $past(lock_bits_o) == 3'h0
      |-> !table_read_block_o && !ext_exec_block_o) else $error("block raised with no lock bit");
   AST_LOCK1_TABLE_BLOCK: assert property (lock_bits_o[0] && $past(lock_bits_o[0])
      && cpu_ext_fetch_i && $past(cpu_ext_fetch_i) |-> table_read_block_o) else $error("table read not blocked");
   AST_LOCK3_EXEC_BLOCK: assert property (lock_bits_o == 3'h7 && $past(lock_bits_o) == 3'h7
      && cpu_ext_fetch_i && $past(cpu_ext_fetch_i) |-> ext_exec_block_o) else $error("external run not blocked");
   AST_WRITE_GOES_BUSY: assert property ($rose(program_strobe_i) && hv_enable_i && reset_pin_i
      && mode_i == `CFPL_PM_WR_CODE && lock_bits_o == 3'h0 && ready_busy_o |-> ##[2:8] !ready_busy_o)
      else $error("no busy after write strobe");
   AST_LOCKED_WRITE_REFUSED: assert property ($rose(program_strobe_i) && mode_i == `CFPL_PM_WR_CODE
      && lock_bits_o[0] && ready_busy_o |=> ready_busy_o [*8]) else $error("locked write went busy");
   AST_BUSY_BOUNDED: assert property (busy_cnt_q <= ERASE_CYC + 32'h8)
      else $error("busy span too long");
   AST_LOCKED_NO_VERIFY: assert property ((lock_bits_o[1:0] != 2'h0 && mode_i == `CFPL_PM_RD_CODE) [*5]
      |-> !data_oe_o) else $error("code driven while locked");
   AST_SERIAL_NEEDS_RESET_PIN: assert property ((!reset_pin_i) [*5] |-> !miso_oe_o)
      else $error("serial out driven with reset pin low");
   AST_LOCK_READBACK: assert property ((mode_i == `CFPL_PM_RD_LOCK && !hv_enable_i && reset_pin_i
      && program_strobe_i && ready_busy_o) [*6] |-> data_o[`CFPL_LB3_POS:`CFPL_LB1_POS] == lock_bits_o)
      else $error("lock readback wrong");
   AST_SIG0_READ: assert property ((mode_i == `CFPL_PM_RD_SIG && addr_i == 13'h0000 && !hv_enable_i
      && reset_pin_i && program_strobe_i) [*6] |-> data_o == SIG0) else $error("signature byte wrong");

   // main scenarios reached
   COV_BUSY: cover property ($fell(ready_busy_o));
   COV_ALL_LOCKS: cover property (lock_bits_o == 3'h7);
   COV_SERIAL_OUT: cover property ($rose(miso_oe_o));
endmodule // cfpl_port_checker

bind cfpl_port cfpl_port_checker #(.ERASE_CYC(ERASE_CYC), .SIG0(SIG0)) cfpl_port_checker_inst (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .reset_pin_i(reset_pin_i), .hv_enable_i(hv_enable_i),
   .program_strobe_i(program_strobe_i), .mode_i(mode_i), .addr_i(addr_i), .cpu_ext_fetch_i(cpu_ext_fetch_i),
   .data_o(data_o), .data_oe_o(data_oe_o), .ready_busy_o(ready_busy_o), .miso_oe_o(miso_oe_o),
   .table_read_block_o(table_read_block_o), .ext_exec_block_o(ext_exec_block_o), .lock_bits_o(lock_bits_o));
`default_nettype wire

// file: cfpl_prog_model.sv
// cfpl_prog_model.sv: external programmer driving parallel and serial lines.
// assumes a 4 ns core clock; the bench calls tasks one at a time.
`timescale 1ns/10ps
`default_nettype none
`include "cfpl_defines.vh"

module cfpl_prog_model (
   input  wire logic        clock_i,          // core clock, parallel lines change on its fall
   input  wire logic        miso_i,           // serial data from the port
   output var  logic        hv_enable_o,      // high voltage on access pin
   output var  logic        program_strobe_o, // active low strobe
   output var  logic [4:0]  mode_o,           // mode control lines
   output var  logic [12:0] addr_o,           // parallel address
   output var  logic [7:0]  data_o,           // parallel data
   output var  logic        sck_o,            // shift clock, low outside frames
   output var  logic        mosi_o            // serial data out
);
   // idle levels
   initial begin
      hv_enable_o = 1'b0;
      program_strobe_o = 1'b1;
      mode_o = `CFPL_PM_RD_CODE;
      addr_o = 13'h0000;
      data_o = 8'h00;
      sck_o = 1'b0;
      mosi_o = 1'b0;
   end
   // present mode and address for a read
   task automatic setup(input logic [4:0] m, input logic [12:0] a);
      @(negedge clock_i);
      mode_o = m;
      addr_o = a;
   endtask

   task automatic par_cmd(input logic [4:0] m, input logic [12:0] a, input logic [7:0] d);
      setup(m, a);
      data_o = d;
      repeat (4) @(negedge clock_i);
      hv_enable_o = 1'b1;
      repeat (4) @(negedge clock_i);
      program_strobe_o = 1'b0;
      repeat (60) @(negedge clock_i);
      program_strobe_o = 1'b1;
      repeat (4) @(negedge clock_i);
      hv_enable_o = 1'b0;
      data_o = ~d; // released data lines stop showing the byte
   endtask

   // four bytes msb first, 8 MHz shift clock
   task automatic ser_frame(input logic [31:0] w, output logic [7:0] r);
      int i;
      r = 8'h00;
      @(negedge clock_i) #0.25;
      for (i = 31; i >= 0; i--) begin
         mosi_o = w[i];
         #62.5;
         sck_o = 1'b1;
         if (i < 8) begin
            r[i] = miso_i;
         end
         #62.5;
         sck_o = 1'b0;
      end
      mosi_o = ~mosi_o; // no stale level
   endtask
endmodule // cfpl_prog_model
`default_nettype wire

// file: cfpl_port_tb.sv
// cfpl_port_tb.sv: self-checking bench for the flash programming port.
// assumes the programmer model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cfpl_defines.vh"

module cfpl_port_tb;
   localparam [31:0] WR_CYC = 32'h07d0; // shortened byte write time
   localparam [31:0] ER_CYC = 32'h0fa0; // shortened erase, longer than one frame
   localparam [7:0]  SIG0   = 8'h5a;    // arbitrary value
   localparam [7:0]  SIG1   = 8'ha5;    // arbitrary value
   localparam [7:0]  SIG2   = 8'h3c;    // arbitrary value

   logic clock_i, rst_b_i, reset_pin_i, ext_access_i, cpu_ext_fetch_i, oe_seen;
   logic hv, strobe, sck, mosi, miso, miso_oe, data_oe, ready_busy_o;
   logic table_read_block_o, ext_exec_block_o, ext_access_latch_o;
   logic [4:0] mode;
   logic [12:0] addr;
   logic [7:0] din, data_o;
   logic [2:0] lock_bits_o;
   int error_cnt = 0;
   int n_compared = 0;

   cfpl_port #(.WRITE_CYC(WR_CYC), .ERASE_CYC(ER_CYC), .SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2)) cfpl_port_inst (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .reset_pin_i(reset_pin_i), .hv_enable_i(hv),
      .ext_access_i(ext_access_i), .program_strobe_i(strobe), .mode_i(mode), .addr_i(addr), .data_i(din),
      .sck_i(sck), .mosi_i(mosi), .cpu_ext_fetch_i(cpu_ext_fetch_i), .data_o(data_o), .data_oe_o(data_oe),
      .ready_busy_o(ready_busy_o), .miso_o(miso), .miso_oe_o(miso_oe), .table_read_block_o(table_read_block_o),
      .ext_exec_block_o(ext_exec_block_o), .ext_access_latch_o(ext_access_latch_o), .lock_bits_o(lock_bits_o));
   cfpl_prog_model cfpl_prog_model_inst (.clock_i(clock_i), .miso_i(miso), .hv_enable_o(hv),
      .program_strobe_o(strobe), .mode_o(mode), .addr_o(addr), .data_o(din), .sck_o(sck), .mosi_o(mosi));

   // remember any drive of the serial output
   always @(posedge clock_i) begin
      if (miso_oe === 1'b1) begin
         oe_seen = 1'b1;
      end
   end

   // one comparison of an eight bit result
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // bounded wait for ready, then judge it
   task automatic wait_ready(input int lim);
      int n;
      n = 0;
      repeat (8) @(negedge clock_i);
      while (ready_busy_o !== 1'b1 && n < lim) begin
         @(negedge clock_i);
         n++;
      end
      chk("ready in time", 8'h01, {7'h0, ready_busy_o});
   endtask

   // parallel read, registered output settles within 8 cycles
   task automatic rd(input logic [4:0] m, input logic [12:0] a);
      cfpl_prog_model_inst.setup(m, a);
      repeat (8) @(negedge clock_i);
   endtask

   task automatic t_reset_sig();
      logic [7:0] sig [3];
      sig = '{SIG0, SIG1, SIG2};
      chk("ready", 8'h01, {7'h0, ready_busy_o});
      chk("locks", 8'h00, {5'h0, lock_bits_o});
      chk("blocks", 8'h00, {6'h0, table_read_block_o, ext_exec_block_o});
      for (int i = 0; i < 3; i++) begin
         rd(`CFPL_PM_RD_SIG, {3'h0, i[1:0], 8'h00});
         chk("signature", sig[i], data_o);
      end
      $display("test reset and signature done");
   endtask

   task automatic t_pwrite();
      cfpl_prog_model_inst.par_cmd(`CFPL_PM_WR_CODE, 13'h1fff, 8'h3c);
      rd(`CFPL_PM_RD_CODE, 13'h1fff);
      chk("busy", 8'h00, {7'h0, ready_busy_o});
      chk("polling byte", 8'hbc, data_o);
      wait_ready(WR_CYC);
      repeat (8) @(negedge clock_i);
      chk("true byte", 8'h3c, data_o);
      $display("test parallel write done");
   endtask

   task automatic t_serial();
      logic [7:0] r;
      oe_seen = 1'b0;
      cfpl_prog_model_inst.ser_frame(32'h211fff00, r);
      chk("ignored frame", 8'h00, {7'h0, oe_seen});
      cfpl_prog_model_inst.ser_frame(32'hac530000, r);
      cfpl_prog_model_inst.ser_frame(32'h211fff00, r);
      chk("serial read", 8'h3c, r);
      cfpl_prog_model_inst.ser_frame(32'hac800000, r);
      cfpl_prog_model_inst.ser_frame(32'h211fff00, r);
      chk("read in erase", 8'h00, r);
      wait_ready(ER_CYC);
      cfpl_prog_model_inst.ser_frame(32'h211fff00, r);
      chk("erased byte", 8'hff, r);
      cfpl_prog_model_inst.ser_frame(32'h42010096, r);
      cfpl_prog_model_inst.ser_frame(32'h21010000, r);
      chk("serial polling", 8'h16, r);
      wait_ready(WR_CYC);
      cfpl_prog_model_inst.ser_frame(32'h21010000, r);
      chk("serial written", 8'h96, r);
      $display("test serial done");
   endtask

   task automatic t_lock();
      cpu_ext_fetch_i = 1'b1;
      cfpl_prog_model_inst.par_cmd(`CFPL_PM_WR_LB1, 13'h0000, 8'h00);
      wait_ready(WR_CYC);
      chk("table block", 8'h01, {7'h0, table_read_block_o});
      cfpl_prog_model_inst.par_cmd(`CFPL_PM_WR_CODE, 13'h0010, 8'h55);
      rd(`CFPL_PM_RD_CODE, 13'h1fff);
      chk("write refused", 8'h01, {7'h0, ready_busy_o});
      chk("verify off", 8'h00, {7'h0, data_oe});
      cfpl_prog_model_inst.par_cmd(`CFPL_PM_WR_LB2, 13'h0000, 8'h00);
      wait_ready(WR_CYC);
      cfpl_prog_model_inst.par_cmd(`CFPL_PM_WR_LB3, 13'h0000, 8'h00);
      wait_ready(WR_CYC);
      chk("exec block", 8'h01, {7'h0, ext_exec_block_o});
      rd(`CFPL_PM_RD_LOCK, 13'h0000);
      chk("lock readback", 8'h1c, data_o & 8'h1c);
      reset_pin_i = 1'b0;
      repeat (8) @(negedge clock_i);
      ext_access_i = 1'b0;
      repeat (8) @(negedge clock_i);
      chk("access latch", 8'h01, {7'h0, ext_access_latch_o});
      ext_access_i = 1'b1;
      reset_pin_i = 1'b1;
      repeat (8) @(negedge clock_i);
      cfpl_prog_model_inst.par_cmd(`CFPL_PM_ERASE, 13'h0000, 8'h00);
      wait_ready(WR_CYC);
      chk("locks erased", 8'h00, {5'h0, lock_bits_o});
      $display("test locks done");
   endtask

   // verdict and end of run
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // 250 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // reset pin raised only after core reset
   initial begin
      rst_b_i = 1'b0;
      reset_pin_i = 1'b0;
      ext_access_i = 1'b1;
      cpu_ext_fetch_i = 1'b0;
      oe_seen = 1'b0;
      repeat (8) @(negedge clock_i);
      rst_b_i = 1'b1;
      repeat (8) @(negedge clock_i);
      reset_pin_i = 1'b1;
      repeat (8) @(negedge clock_i);
      t_reset_sig();
      t_pwrite();
      t_serial();
      t_lock();
      tally_and_finish();
   end

   // watchdog, four times the expected run
   initial begin
      #400000;
      error_cnt++;
      $display("ERROR watchdog expected finished seen running");
      tally_and_finish();
   end
endmodule // cfpl_port_tb
`default_nettype wire
